// ---- tdsup_map.svh ----
/*
 constants of the tough-drive supervisor: offsets, fields, resets, timing.
 assumes inclusion by bare name from the package and the design files.
*/
// Contract
// - one setting enables or disables all ride-through supervision
// - retune only if resonance within 30 percent of filter 1 or 2
// - overwrite only the filter frequency closer to the detected one
// - retune freely, commit to nonvolatile store at most once an hour
// - never touch filters 3, 4 or 5
// - resonance at or below 100 Hz never triggers a retune
// - detection sensitivity comes from a detection-level setting
// - filter 4 enabled turns the shaft resonance filter off
// - robust filter enabled turns filter 5 off
// - ride-through start switches the undervoltage threshold at once
// - supply-drop detection time comes from a setting
// - loss longer than detection time raises the undervoltage alarm
// - ride-through output on once a loss is detected
// - brake interlock stays on through ride-through
// - brake interlock drops when the undervoltage alarm rises
// - bus at or below 200 V during ride-through still alarms
// - short loss with healthy bus continues without alarm
// - torque limit option 1 limits torque during a loss
// - bus-drop alarm may come regardless of detection time
`ifndef TDSUP_MAP_SVH
`define TDSUP_MAP_SVH
// register word offsets
`define TDS_A_CTRL  4'h0
`define TDS_A_FILT1 4'h1
`define TDS_A_FILT2 4'h2
`define TDS_A_FILT3 4'h3
`define TDS_A_FILT4 4'h4
`define TDS_A_FILT5 4'h5
`define TDS_A_OSC   4'h6
`define TDS_A_DTIME 4'h7
`define TDS_A_UVLVL 4'h8
`define TDS_A_STAT  4'h9
// control field positions
`define TDS_C_EN  0
`define TDS_C_TQ  1
`define TDS_C_F4  2
`define TDS_C_ROB 3
`define TDS_C_F5  4
`define TDS_C_CLR 5
// reset values
`define TDS_CTRL_RST  16'h0000
`define TDS_FILT_RST  16'h1194
`define TDS_OSC_RST   16'h0032
`define TDS_DTIME_RST 16'h00C8
`define TDS_UVLVL_RST 16'h00F0
// thresholds
`define TDS_RIDE_UV_V 16'h00C8
`define TDS_MIN_HZ    16'h0064
`define TDS_WIN_PCT   30
// timing: ms prescale from the 40 MHz clock, hour in ms
`define TDS_CLK_HZ    40000000
`define TDS_MS_PER_S  1000
`define TDS_MS_CYC    (`TDS_CLK_HZ / `TDS_MS_PER_S)
`define TDS_HOUR_MS   3600000
`endif

// ---- tdsup_pkg.sv ----
/*
 types of the tough-drive supervisor.
 assumes tdsup_map.svh sits in the same folder.
*/
`include "tdsup_map.svh"
package tdsup_pkg;
  typedef enum logic [1:0] {
    PL_IDLE  = 2'b00,
    PL_RIDE  = 2'b01,
    PL_ALARM = 2'b11
  } tdsup_pl_e;
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } tdsup_bus_s;
  typedef struct packed {
    logic        valid;
    logic [15:0] freq;
    logic [15:0] level;
  } tdsup_res_s;
  typedef struct packed {
    logic        stb;
    logic        sel;
    logic [15:0] freq;
  } tdsup_nvm_s;
  typedef struct packed {
    logic uv;
    logic supply;
    logic busd;
  } tdsup_alm_s;
  typedef struct packed {
    tdsup_pl_e        pl;
    logic [15:0]      tmr_ms;
    logic [31:0]      ms_cnt;
    logic [31:0]      hold_ms;
    logic             hold_busy;
    logic             pend;
    logic             pend_sel;
    logic [15:0]      pend_freq;
    logic [5:0]       ctrl;
    logic [4:0][15:0] filt;
    logic [15:0]      osc;
    logic [15:0]      dtime;
    logic [15:0]      uvlvl;
    logic [15:0]      rdata;
    logic             active;
    logic             brake;
    logic             torque;
    logic             shaft;
    logic             f5;
    tdsup_alm_s       alm;
    tdsup_nvm_s       nvm;
  } tdsup_state_s;
endpackage : tdsup_pkg

// ---- tdsup_sync2.sv ----
/*
 two-flop synchroniser for one level from outside the clock domain.
 assumes a single clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tdsup_sync2 (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic d_in,
  output var  logic q_out
);
  logic [1:0] st_r;
  logic [1:0] st_nxt;

  // first stage feeds only the second
  always_comb begin
    st_nxt = {st_r[0], d_in};
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r <= 2'h0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_out = st_r[1];
endmodule : tdsup_sync2
`default_nettype wire

// ---- tdsup_top.sv ----
/*
 tough-drive supervisor: resonance filter retuning with hourly commit,
 and power-loss ride-through with alarms, brake interlock, torque limit.
 assumes a detector, bus-voltage monitor and register master on ref_clk;
 the power-loss flag is a pin and is synchronised here.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tdsup_map.svh"
module tdsup_top
  import tdsup_pkg::*;
#(
  parameter int MS_CYCLES = `TDS_MS_CYC,
  parameter int HOUR_MS   = `TDS_HOUR_MS
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire tdsup_pkg::tdsup_bus_s bus_in,
  output var  logic [15:0]       rd_data,
  input  wire tdsup_pkg::tdsup_res_s res_in,
  input  wire logic [15:0]       bus_volt_in,
  input  wire logic              power_loss_in,
  output var  logic              ride_through_active_out,
  output var  logic              brake_interlock_out,
  output var  logic              torque_limit_out,
  output var  logic              shaft_filter_en_out,
  output var  logic              filter5_en_out,
  output var  tdsup_pkg::tdsup_alm_s alarm_out,
  output var  tdsup_pkg::tdsup_nvm_s nvm_out
);
  import tdsup_pkg::*;

  // refuse counts that the tick and hold-off counters cannot serve
  if (MS_CYCLES < 1 || HOUR_MS < 1) begin : g_bad_counts
    $error("tdsup_top: counts must be at least one");
  end

  tdsup_state_s st_r;
  tdsup_state_s st_nxt;
  logic         loss_s;
  logic         ms_tick;
  logic         wr_ctrl;
  logic [15:0]  d1;
  logic [15:0]  d2;
  logic         in1;
  logic         in2;
  logic         hit;
  logic         pick2;
  logic [15:0]  uv_thr;

  // power-loss pin into the clock domain
  tdsup_sync2 u_loss_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .d_in    (power_loss_in),
    .q_out   (loss_s)
  );

  // absolute difference of two frequencies
  function automatic logic [15:0] absdiff(input logic [15:0] a,
                                          input logic [15:0] b);
    absdiff = (a > b) ? (a - b) : (b - a);
  endfunction : absdiff

  // within the window when diff*100 <= ref*pct
  function automatic logic inwin(input logic [15:0] d,
                                 input logic [15:0] f);
    logic [23:0] lhs;
    logic [23:0] rhs;
    lhs = 24'(d) * 24'd100;
    rhs = 24'(f) * 24'(`TDS_WIN_PCT);
    inwin = (lhs <= rhs);
  endfunction : inwin

  // retune decision from the current detector sample
  always_comb begin
    d1  = absdiff(res_in.freq, st_r.filt[0]);
    d2  = absdiff(res_in.freq, st_r.filt[1]);
    in1 = inwin(d1, st_r.filt[0]);
    in2 = inwin(d2, st_r.filt[1]);
    hit = res_in.valid && st_r.ctrl[`TDS_C_EN]
        && (res_in.freq > `TDS_MIN_HZ)
        && (res_in.level >= st_r.osc)
        && (in1 || in2);
    pick2 = (d2 < d1);
  end

  // threshold switches with the ride-through state
  always_comb begin
    uv_thr = (st_r.pl == PL_RIDE) ? `TDS_RIDE_UV_V : st_r.uvlvl;
  end

  assign ms_tick = (st_r.ms_cnt == 32'(MS_CYCLES - 1));
  assign wr_ctrl = bus_in.wr && (bus_in.addr == `TDS_A_CTRL);

  // whole next-state computation
  always_comb begin
    st_nxt = st_r;
    st_nxt.nvm.stb = 1'b0;
    st_nxt.ctrl[`TDS_C_CLR] = 1'b0;
    st_nxt.ms_cnt = ms_tick ? 32'h0 : st_r.ms_cnt + 32'h1;

    // register writes
    if (bus_in.wr) begin
      case (bus_in.addr)
        `TDS_A_CTRL:  st_nxt.ctrl  = bus_in.wdata[5:0];
        `TDS_A_FILT1: st_nxt.filt[0] = bus_in.wdata;
        `TDS_A_FILT2: st_nxt.filt[1] = bus_in.wdata;
        `TDS_A_FILT3: st_nxt.filt[2] = bus_in.wdata;
        `TDS_A_FILT4: st_nxt.filt[3] = bus_in.wdata;
        `TDS_A_FILT5: st_nxt.filt[4] = bus_in.wdata;
        `TDS_A_OSC:   st_nxt.osc   = bus_in.wdata;
        `TDS_A_DTIME: st_nxt.dtime = bus_in.wdata;
        `TDS_A_UVLVL: st_nxt.uvlvl = bus_in.wdata;
        default:      st_nxt.ctrl  = st_nxt.ctrl;
      endcase
    end

    // hourly hold-off between commits
    if (st_r.hold_busy && ms_tick) begin
      if (st_r.hold_ms == 32'(HOUR_MS - 1)) begin
        st_nxt.hold_busy = 1'b0;
        st_nxt.hold_ms   = 32'h0;
      end else begin
        st_nxt.hold_ms = st_r.hold_ms + 32'h1;
      end
    end

    // commit pending value when no hourly hold-off is running
    if (st_r.pend && !st_r.hold_busy) begin
      st_nxt.nvm.stb   = 1'b1;
      st_nxt.nvm.sel   = st_r.pend_sel;
      st_nxt.nvm.freq  = st_r.pend_freq;
      st_nxt.pend      = 1'b0;
      st_nxt.hold_busy = 1'b1;
      st_nxt.hold_ms   = 32'h0;
    end

    // retune only filter 1 or 2; beats a same-cycle write
    if (hit) begin
      if (pick2) begin
        st_nxt.filt[1] = res_in.freq;
      end else begin
        st_nxt.filt[0] = res_in.freq;
      end
      st_nxt.pend      = 1'b1;
      st_nxt.pend_sel  = pick2;
      st_nxt.pend_freq = res_in.freq;
    end

    // power-loss ride-through state machine
    case (st_r.pl)
      PL_IDLE: begin
        st_nxt.tmr_ms = 16'h0;
        if (bus_volt_in <= uv_thr) begin
          st_nxt.pl = PL_ALARM;
          st_nxt.alm.busd = 1'b1;
        end else if (loss_s && st_r.ctrl[`TDS_C_EN]) begin
          st_nxt.pl = PL_RIDE;
        end else if (loss_s) begin
          st_nxt.pl = PL_ALARM;
          st_nxt.alm.supply = 1'b1;
        end
      end
      PL_RIDE: begin
        if (ms_tick && st_r.tmr_ms != 16'hFFFF) begin
          st_nxt.tmr_ms = st_r.tmr_ms + 16'h1;
        end
        if (bus_volt_in <= uv_thr) begin
          st_nxt.pl = PL_ALARM;
          st_nxt.alm.busd = 1'b1;
        end else if (st_r.tmr_ms >= st_r.dtime) begin
          st_nxt.pl = PL_ALARM;
          st_nxt.alm.supply = 1'b1;
        end else if (!loss_s || !st_r.ctrl[`TDS_C_EN]) begin
          st_nxt.pl = PL_IDLE;
        end
      end
      PL_ALARM: begin
        st_nxt.tmr_ms = 16'h0;
        if (wr_ctrl && bus_in.wdata[`TDS_C_CLR] && !loss_s
            && (bus_volt_in > st_r.uvlvl)) begin
          st_nxt.pl  = PL_IDLE;
          st_nxt.alm = '0;
        end
      end
      default: begin
        st_nxt.pl = PL_IDLE;
      end
    endcase

    // outputs from the next state so they stay aligned with it
    st_nxt.alm.uv   = (st_nxt.pl == PL_ALARM);
    st_nxt.active   = (st_nxt.pl == PL_RIDE);
    st_nxt.brake    = (st_nxt.pl != PL_ALARM);
    st_nxt.torque   = (st_nxt.pl == PL_RIDE)
                    && st_nxt.ctrl[`TDS_C_TQ];
    st_nxt.shaft    = !st_nxt.ctrl[`TDS_C_F4];
    st_nxt.f5       = st_nxt.ctrl[`TDS_C_F5]
                    && !st_nxt.ctrl[`TDS_C_ROB];

    // read data in the cycle after the strobe
    st_nxt.rdata = 16'h0;
    if (bus_in.rd) begin
      case (bus_in.addr)
        `TDS_A_CTRL:  st_nxt.rdata = {10'h0, st_r.ctrl};
        `TDS_A_FILT1: st_nxt.rdata = st_r.filt[0];
        `TDS_A_FILT2: st_nxt.rdata = st_r.filt[1];
        `TDS_A_FILT3: st_nxt.rdata = st_r.filt[2];
        `TDS_A_FILT4: st_nxt.rdata = st_r.filt[3];
        `TDS_A_FILT5: st_nxt.rdata = st_r.filt[4];
        `TDS_A_OSC:   st_nxt.rdata = st_r.osc;
        `TDS_A_DTIME: st_nxt.rdata = st_r.dtime;
        `TDS_A_UVLVL: st_nxt.rdata = st_r.uvlvl;
        `TDS_A_STAT:  st_nxt.rdata = {5'h0, st_r.pl, st_r.hold_busy,
                                      st_r.pend, st_r.f5, st_r.shaft,
                                      st_r.alm.busd, st_r.alm.supply,
                                      st_r.alm.uv, st_r.brake,
                                      st_r.active};
        default:      st_nxt.rdata = 16'h0;
      endcase
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_r           <= '0;
      st_r.pl        <= PL_IDLE;
      st_r.ctrl      <= 6'(`TDS_CTRL_RST);
      st_r.filt      <= {5{`TDS_FILT_RST}};
      st_r.osc       <= `TDS_OSC_RST;
      st_r.dtime     <= `TDS_DTIME_RST;
      st_r.uvlvl     <= `TDS_UVLVL_RST;
      st_r.brake     <= 1'b1;
      st_r.shaft     <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data                 = st_r.rdata;
  assign ride_through_active_out = st_r.active;
  assign brake_interlock_out     = st_r.brake;
  assign torque_limit_out        = st_r.torque;
  assign shaft_filter_en_out     = st_r.shaft;
  assign filter5_en_out          = st_r.f5;
  assign alarm_out               = st_r.alm;
  assign nvm_out                 = st_r.nvm;

  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_off_no_ride;
    !st_r.ctrl[`TDS_C_EN] |=> st_r.pl != PL_RIDE;
  endproperty
  a_off_no_ride: assert property (p_off_no_ride)
    else $error("ride-through while disabled");

  property p_low_no_tune;
    res_in.valid && (res_in.freq <= `TDS_MIN_HZ) && !bus_in.wr
      |=> $stable(st_r.filt[0]) && $stable(st_r.filt[1]);
  endproperty
  a_low_no_tune: assert property (p_low_no_tune)
    else $error("retune from low frequency");

  property p_keep345;
    !(bus_in.wr && bus_in.addr >= `TDS_A_FILT3
      && bus_in.addr <= `TDS_A_FILT5)
      |=> $stable(st_r.filt[4:2]);
  endproperty
  a_keep345: assert property (p_keep345)
    else $error("filter 3-5 changed");

  property p_one_commit;
    st_r.nvm.stb |-> st_r.hold_busy ##1 !st_r.nvm.stb [*8];
  endproperty
  a_one_commit: assert property (p_one_commit)
    else $error("commit without hold-off");

  property p_ride_out;
    st_r.pl == PL_RIDE |-> st_r.active && st_r.brake;
  endproperty
  a_ride_out: assert property (p_ride_out)
    else $error("ride outputs wrong");

  property p_alarm_brake;
    $rose(st_r.alm.uv) |-> !st_r.brake && !st_r.active;
  endproperty
  a_alarm_brake: assert property (p_alarm_brake)
    else $error("brake held at alarm");

  property p_bus_low;
    st_r.pl == PL_RIDE && bus_volt_in <= `TDS_RIDE_UV_V
      |=> st_r.alm.uv && st_r.alm.busd;
  endproperty
  a_bus_low: assert property (p_bus_low)
    else $error("no alarm at low bus");

  property p_timeout;
    st_r.pl == PL_RIDE && st_r.tmr_ms >= st_r.dtime
      && bus_volt_in > `TDS_RIDE_UV_V |=> st_r.alm.supply;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("no alarm after detection time");

  property p_torque;
    st_r.torque |-> st_r.active && st_r.ctrl[`TDS_C_TQ];
  endproperty
  a_torque: assert property (p_torque)
    else $error("torque limit outside loss");

  property p_shaft;
    $rose(st_r.ctrl[`TDS_C_F4]) |-> !st_r.shaft;
  endproperty
  a_shaft: assert property (p_shaft)
    else $error("shaft filter on with filter 4");

  property p_f5_robust;
    st_r.ctrl[`TDS_C_ROB] |-> !st_r.f5;
  endproperty
  a_f5_robust: assert property (p_f5_robust)
    else $error("filter 5 on with robust filter");

  property p_ride_entry;
    st_r.pl == PL_IDLE && loss_s && st_r.ctrl[`TDS_C_EN]
      && bus_volt_in > st_r.uvlvl |=> st_r.active;
  endproperty
  a_ride_entry: assert property (p_ride_entry)
    else $error("no ride-through after loss");

  property p_ride_thr;
    st_r.pl == PL_RIDE && loss_s && st_r.ctrl[`TDS_C_EN]
      && bus_volt_in > `TDS_RIDE_UV_V && st_r.tmr_ms < st_r.dtime
      |=> st_r.active && !st_r.alm.uv;
  endproperty
  a_ride_thr: assert property (p_ride_thr)
    else $error("normal threshold used in ride-through");

  property p_ride_end;
    st_r.pl == PL_RIDE && !loss_s && bus_volt_in > `TDS_RIDE_UV_V
      && st_r.tmr_ms < st_r.dtime |=> !st_r.active && !st_r.alm.uv;
  endproperty
  a_ride_end: assert property (p_ride_end)
    else $error("ride-through output held after loss");

  c_retune: cover property (hit ##1 st_r.pend);
  c_ride_ok: cover property (st_r.pl == PL_RIDE ##1 st_r.pl == PL_IDLE);
  c_supply: cover property ($rose(st_r.alm.supply));
  c_commit: cover property (st_r.nvm.stb);
endmodule : tdsup_top
`default_nettype wire

// ---- tdsup_mains_model.sv ----
/*
 mains and dc bus model on the far side of the supervisor.
 assumes the bench commands mains loss and bus voltage on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module tdsup_mains_model (
  input  wire logic        ref_clk,
  input  wire logic        mains_off,
  input  wire logic [15:0] volt_set,
  output var  logic        power_loss_in,
  output var  logic [15:0] bus_volt_in
);
  // healthy mains and a charged bus at start
  initial begin
    power_loss_in = 1'b0;
    bus_volt_in   = 16'h012C;
  end
  // pin and bus level follow the command one edge later
  always @(posedge ref_clk) begin
    power_loss_in <= mains_off;
    bus_volt_in   <= volt_set;
  end
endmodule : tdsup_mains_model
`default_nettype wire

// ---- tough_drive_supervisor_bench.sv ----
/*
 self-checking bench of the tough-drive supervisor.
 assumes tdsup_pkg, tdsup_top and tdsup_mains_model compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module tough_drive_supervisor_bench;
  import tdsup_pkg::*;
  logic        ref_clk   = 1'b0;
  logic        rst       = 1'b1;
  tdsup_bus_s  bus_r     = '0;
  tdsup_res_s  res_r     = '0;
  logic        mains_off = 1'b0;
  logic [15:0] volt_set  = 16'h012C;
  logic        loss_w;
  logic [15:0] volt_w;
  logic [15:0] rd_data;
  logic        active;
  logic        brake;
  logic        torque;
  logic        shaft;
  logic        f5;
  tdsup_alm_s  alarm;
  tdsup_nvm_s  nvm;
  int          n_errors  = 0;
  int          n_tests   = 0;
  int          n;
  // short ms tick and hour so hold-off fits the run
  tdsup_top #(.MS_CYCLES(4), .HOUR_MS(3)) tdsup_top_i (
    .ref_clk(ref_clk), .rst(rst), .bus_in(bus_r), .rd_data(rd_data), .res_in(res_r),
    .bus_volt_in(volt_w), .power_loss_in(loss_w), .ride_through_active_out(active),
    .brake_interlock_out(brake), .torque_limit_out(torque), .shaft_filter_en_out(shaft),
    .filter5_en_out(f5), .alarm_out(alarm), .nvm_out(nvm)
  );
  tdsup_mains_model tdsup_mains_model_i (
    .ref_clk(ref_clk), .mains_off(mains_off), .volt_set(volt_set),
    .power_loss_in(loss_w), .bus_volt_in(volt_w)
  );
  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;
  task complete_run;
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : complete_run
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task tick(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask : tick
  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    bus_r.wr    <= 1'b1;
    bus_r.addr  <= a;
    bus_r.wdata <= d;
    @(posedge ref_clk);
    bus_r.wr    <= 1'b0;
  endtask : wr_reg
  task chk_reg(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    bus_r.rd   <= 1'b1;
    bus_r.addr <= a;
    @(posedge ref_clk);
    bus_r.rd   <= 1'b0;
    #1;
    chk("register", exp, rd_data);
  endtask : chk_reg
  task pulse_res(input logic [15:0] f, input logic [15:0] l);
    @(posedge ref_clk);
    res_r <= '{valid: 1'b1, freq: f, level: l};
    @(posedge ref_clk);
    res_r.valid <= 1'b0;
    #1;
  endtask : pulse_res
  function automatic logic sig(input int w);
    case (w)
      0:       return nvm.stb;
      1:       return active;
      default: return alarm.uv;
    endcase
  endfunction : sig
  // bounded wait for a watched output to go high
  task wait_hi(input int w, input int lim);
    n = 0;
    #1; // look past the launching edge
    while (sig(w) !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
    chk("awaited output", 16'h0001, {15'h0000, sig(w)});
  endtask : wait_hi
  task clear_alarm;
    volt_set  <= 16'h012C;
    mains_off <= 1'b0;
    tick(4);
    wr_reg(`TDS_A_CTRL, 16'h0023);
    tick(2);
    chk("uv cleared", 16'h0000, {15'h0000, alarm.uv});
  endtask : clear_alarm
  task t_reset;
    chk("brake", 16'h0001, {15'h0000, brake});
    chk("shaft", 16'h0001, {15'h0000, shaft});
    chk("filter5", 16'h0000, {15'h0000, f5});
    chk_reg(`TDS_A_CTRL, 16'h0000);
    for (int a = 1; a < 6; a++)
      chk_reg(a[3:0], 16'h1194);
    chk_reg(`TDS_A_OSC, 16'h0032);
    chk_reg(`TDS_A_DTIME, 16'h00C8);
    chk_reg(`TDS_A_UVLVL, 16'h00F0);
    wr_reg(4'hC, 16'hFFFF);
    chk_reg(4'hC, 16'h0000);
  endtask : t_reset
  task t_filters;
    wr_reg(`TDS_A_CTRL, 16'h0004);
    tick(2);
    chk("shaft off", 16'h0000, {15'h0000, shaft});
    wr_reg(`TDS_A_CTRL, 16'h0010);
    tick(2);
    chk("filter5 on", 16'h0001, {15'h0000, f5});
    wr_reg(`TDS_A_CTRL, 16'h0018);
    tick(2);
    chk("filter5 robust", 16'h0000, {15'h0000, f5});
  endtask : t_filters
  task t_retune;
    wr_reg(`TDS_A_CTRL, 16'h0000);
    wr_reg(`TDS_A_FILT1, 16'h03E8);
    wr_reg(`TDS_A_FILT2, 16'h07D0);
    pulse_res(16'h044C, 16'h0064);
    chk_reg(`TDS_A_FILT1, 16'h03E8);
    wr_reg(`TDS_A_CTRL, 16'h0001);
    pulse_res(16'h044C, 16'h000A);
    chk_reg(`TDS_A_FILT1, 16'h03E8);
    pulse_res(16'h0546, 16'h0064);
    chk_reg(`TDS_A_FILT1, 16'h03E8);
    chk_reg(`TDS_A_FILT2, 16'h07D0);
    pulse_res(16'h044C, 16'h0064);
    wait_hi(0, 6);
    chk("commit sel", 16'h0000, {15'h0000, nvm.sel});
    chk("commit freq", 16'h044C, nvm.freq);
    pulse_res(16'h076C, 16'h0064);
    chk_reg(`TDS_A_FILT1, 16'h044C);
    chk_reg(`TDS_A_FILT2, 16'h076C);
    wait_hi(0, 20);
    chk("hold-off wait", 16'h0001, {15'h0000, n >= 2});
    chk("commit sel 2", 16'h0001, {15'h0000, nvm.sel});
    chk("commit freq 2", 16'h076C, nvm.freq);
    for (int a = 3; a < 6; a++)
      chk_reg(a[3:0], 16'h1194);
    wr_reg(`TDS_A_FILT1, 16'h006E);
    pulse_res(16'h0064, 16'h0064);
    chk_reg(`TDS_A_FILT1, 16'h006E);
  endtask : t_retune
  task t_long_loss;
    wr_reg(`TDS_A_DTIME, 16'h0003);
    wr_reg(`TDS_A_CTRL, 16'h0003);
    mains_off <= 1'b1;
    wait_hi(1, 8);
    chk("torque limit", 16'h0001, {15'h0000, torque});
    tick(8);
    chk("no early alarm", 16'h0000, {15'h0000, alarm.uv});
    chk("brake held", 16'h0001, {15'h0000, brake});
    wait_hi(2, 12);
    chk("supply alarm", 16'h0001, {15'h0000, alarm.supply});
    chk("brake drop", 16'h0000, {15'h0000, brake});
    chk("active off", 16'h0000, {15'h0000, active});
    clear_alarm();
  endtask : t_long_loss
  task t_short_loss;
    mains_off <= 1'b1;
    wait_hi(1, 8);
    volt_set <= 16'h00DC;
    tick(3);
    volt_set <= 16'h012C;
    tick(2);
    mains_off <= 1'b0;
    tick(6);
    chk("no alarm", 16'h0000, {15'h0000, alarm.uv});
    chk("active end", 16'h0000, {15'h0000, active});
  endtask : t_short_loss
  task t_bus_drop;
    mains_off <= 1'b1;
    wait_hi(1, 8);
    volt_set <= 16'h00C8;
    wait_hi(2, 6);
    chk("bus drop alarm", 16'h0001, {15'h0000, alarm.busd});
    chk("no supply alarm", 16'h0000, {15'h0000, alarm.supply});
    chk("brake drop", 16'h0000, {15'h0000, brake});
    clear_alarm();
  endtask : t_bus_drop
  task t_disabled;
    wr_reg(`TDS_A_CTRL, 16'h0000);
    mains_off <= 1'b1;
    wait_hi(2, 8);
    chk("no ride", 16'h0000, {15'h0000, active});
    clear_alarm();
  endtask : t_disabled
  // main sequence
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    tick(3);
    t_reset();
    t_filters();
    t_retune();
    t_long_loss();
    t_short_loss();
    t_bus_drop();
    t_disabled();
    complete_run();
  end
  // watchdog well beyond the expected few hundred cycles
  initial begin
    #(25 * 20000);
    n_errors++;
    complete_run();
  end
endmodule : tough_drive_supervisor_bench
`default_nettype wire
